// ---- include/istar_pkg.sv ----
// Shared constants, types and states of the serial slave with temperature and trim registers
package istar_pkg;
   // ****************************************************************
   // Bus address and register map
   // ****************************************************************
   localparam logic [6:0] DEV_ADDR       = 7'h68;
   localparam logic [7:0] ADDR_TRIM      = 8'h10;
   localparam logic [7:0] ADDR_TEMP_INT  = 8'h11;
   localparam logic [7:0] ADDR_TEMP_FRAC = 8'h12;
   localparam logic [7:0] SRAM_FIRST     = 8'h14;
   localparam int         SRAM_WORDS     = 236;
   localparam int         TRIM_SIGN_BIT  = 7;
   localparam int         TEMP_FRAC_POS  = 6;
   // ****************************************************************
   // Reset values and capacitance limit
   // ****************************************************************
   localparam logic [9:0] TEMP_RESET     = 10'h000;
   localparam logic [7:0] TRIM_RESET     = 8'h00;
   localparam logic [7:0] PTR_RESET      = 8'h00;
   localparam logic [7:0] CAP_RESET      = 8'h00;
   localparam logic [7:0] CAP_MAX        = 8'hff;
   // ****************************************************************
   // Timing and write FIFO size
   // ****************************************************************
   localparam longint CLK_HZ        = 200_000_000;
   localparam longint MANUAL_CONVERT_BIT_PERIOD_S = 64;
   localparam logic [39:0] MANUAL_CONVERT_BIT_PERIOD_CYCLES = 40'(MANUAL_CONVERT_BIT_PERIOD_S * CLK_HZ);
   localparam int     FIFO_DEPTH    = 32;
   localparam int     FIFO_WIDTH    = 16;
   // ****************************************************************
   // Types
   // ****************************************************************
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] data;
   } istar_wr_t;
   typedef struct packed {
      logic       valid;
      logic [9:0] code;
   } istar_temp_t;
   typedef enum logic [2:0] {
      ST_IDLE     = 3'b000,
      ST_ADDR     = 3'b001,
      ST_ADDR_ACK = 3'b010,
      ST_WR_BYTE  = 3'b011,
      ST_WR_ACK   = 3'b100,
      ST_RD_BYTE  = 3'b101,
      ST_RD_ACK   = 3'b110
   } istar_state_t;
endpackage

// ---- core/istar_slave.sv ----
// Serial slave with write FIFO, temperature result, aging trim and user SRAM
`timescale 1ns/10ps

// ****************************************************************
// Write FIFO
// ****************************************************************
module istar_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 32
) (
   input  wire logic             ref_clk_in,
   input  wire logic             resetn_in,
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   output logic                  out_valid_out,
   input  wire logic             out_ready_in,
   output logic [WIDTH-1:0]      out_data_out
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [0:DEPTH-1];
   logic [AW:0]      wr_q;
   logic [AW:0]      rd_q;
   wire              push = in_valid_in & in_ready_out;
   wire              pop  = out_valid_out & out_ready_in;

   // Extra pointer bit tells full from empty
   assign in_ready_out  = (wr_q[AW-1:0] != rd_q[AW-1:0]) || (wr_q[AW] == rd_q[AW]);
   assign out_valid_out = (wr_q != rd_q);
   assign out_data_out  = mem_q[rd_q[AW-1:0]];

   // Storage has no reset; only the pointers need one
   always_ff @(posedge ref_clk_in) begin
      if (push) begin
         mem_q[wr_q[AW-1:0]] <= in_data_in;
      end
   end

   // Pointer update
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         wr_q <= wr_q + (AW+1)'(push);
         rd_q <= rd_q + (AW+1)'(pop);
      end
   end
endmodule

// Overview of operation
// - SRAM bytes from 14h upward start undefined; no initial content assumed.
// - Aging trim byte is two's complement with bit 7 as sign.
// - Trim adds to capacitance at changed-temperature periodic or at manual conversion.
// - Positive trim adds capacitance, slower; negative removes it, faster.
// - Temperature is 10-bit two's complement, quarter degrees; integer in first byte.
// - Two fraction bits sit at top of second byte; rest read zero.
// - Reset presets temperature to zero and starts a conversion at once.
// - Convert at power-up, bus access on backup, every 64 s; update results.
// - Bus writes to both temperature bytes are ignored.
// - Slave only, open-drain data, works at 100 kHz and 400 kHz.
// - Data changes only while clock low; change while high is a condition.
// - Data falling with clock high is START; rising is STOP.
// - Bytes each followed by ninth acknowledge slot; byte count set by master.
// - Addressed receiver holds data low through acknowledge clock high phase.
// - Master does not acknowledge last read byte; device then releases data.
// - Every byte shifts most significant bit first.
// - Write: address byte then data bytes; device acknowledges each received byte; a data byte meeting a full write FIFO gets a not-acknowledge instead.
// - Read: device acknowledges address then sends bytes; master acks all but last.
// - Transfer ends with STOP or repeated START, which opens the next.
// - Direction bit after address selects write or read.
// - Respond only to fixed seven-bit address; direction 0 write, 1 read.
// - First write byte loads register pointer; pointer advances per data byte.
// - Read starts at current pointer, which keeps its last value.
module istar_slave #(
   parameter logic [39:0] MANUAL_CONVERT_BIT_PERIOD = istar_pkg::MANUAL_CONVERT_BIT_PERIOD_CYCLES
) (
   input  wire logic                   ref_clk_in,
   input  wire logic                   resetn_in,
   input  wire logic                   scl_in,
   input  wire logic                   sda_in,
   output logic                        sda_out,
   output logic                        sda_oe_n_out,
   input  wire logic                   on_backup_in,
   input  wire logic                   manual_convert_in,
   output logic                        manual_convert_bit_start_out,
   output logic                        manual_convert_bit_busy_out,
   input  wire istar_pkg::istar_temp_t temp_result_in,
   input  wire logic [7:0]             cap_base_in,
   output logic [7:0]                  cap_trim_out
);
   import istar_pkg::*;

   // ****************************************************************
   // Signed trim applied to the computed capacitance
   // ****************************************************************
   // Clamped so a large negative trim cannot wrap to full capacitance
   function automatic logic [7:0] cap_apply(input logic [7:0] base, input logic [7:0] trim);
      logic signed [9:0] sum;
      sum = $signed({2'b00, base}) + $signed({{2{trim[TRIM_SIGN_BIT]}}, trim});
      if (sum < 0) begin
         return CAP_RESET;
      end else if (sum > $signed({2'b00, CAP_MAX})) begin
         return CAP_MAX;
      end
      return sum[7:0];
   endfunction

   // ****************************************************************
   // Declarations
   // ****************************************************************
   logic              scl_m_q, scl_s_q, scl_p_q;
   logic              sda_m_q, sda_s_q, sda_p_q;
   logic              bk_m_q, bk_s_q;
   istar_state_t      state_q;
   logic [3:0]        bitcnt_q;
   logic [7:0]        shift_q;
   logic [7:0]        tx_q;
   logic [7:0]        ptr_q;
   logic              rw_q;
   logic              first_q;
   logic              nack_q;
   logic              oe_n_q;
   logic [7:0]        sram_q [0:SRAM_WORDS-1];
   logic [7:0]        trim_q;
   logic [9:0]        temp_q;
   logic [7:0]        cap_q;
   logic              pend_q, busy_q, man_q, start_q;
   logic [39:0]       per_cnt_q;
   logic              push_ready;
   logic              pop_valid;
   istar_wr_t         pop_data;
   logic [7:0]        rd_data;

   // ****************************************************************
   // Pin synchronisers and bus condition detect
   // ****************************************************************
   // Pins come from another domain; first stage feeds only the second
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         {scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
         {sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
         {bk_m_q, bk_s_q}            <= 2'h0;
      end else begin
         {scl_m_q, scl_s_q, scl_p_q} <= {scl_in, scl_m_q, scl_s_q};
         {sda_m_q, sda_s_q, sda_p_q} <= {sda_in, sda_m_q, sda_s_q};
         {bk_m_q, bk_s_q}            <= {on_backup_in, bk_m_q};
      end
   end

   // Edges of the bus clock; conditions need clock high on both samples
   wire scl_rise  = scl_s_q & ~scl_p_q;
   wire scl_fall  = ~scl_s_q & scl_p_q;
   wire start_det = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
   wire stop_det  = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

   // ****************************************************************
   // Byte decode
   // ****************************************************************
   wire byte_done = scl_fall & (bitcnt_q == 4'h8);
   wire addr_hit  = (shift_q[7:1] == DEV_ADDR);
   wire wr_data   = (state_q == ST_WR_BYTE) & byte_done & ~first_q;
   wire push      = wr_data & push_ready;
   wire ld_tx     = scl_fall & (((state_q == ST_ADDR_ACK) & rw_q) |
                                ((state_q == ST_RD_ACK) & ~nack_q));
   wire tx_last   = (state_q == ST_RD_BYTE) & scl_fall & (bitcnt_q == 4'h7);
   wire [7:0] sram_idx = ptr_q - SRAM_FIRST;

   // Read mux; unmapped locations and unused bits read zero
   assign rd_data = (ptr_q == ADDR_TRIM)      ? trim_q :
                    (ptr_q == ADDR_TEMP_INT)  ? temp_q[9:2] :
                    (ptr_q == ADDR_TEMP_FRAC) ? {temp_q[1:0], 6'h00} :
                    (ptr_q >= SRAM_FIRST)     ? sram_q[sram_idx] : 8'h00;

   // ****************************************************************
   // Transfer state machine
   // ****************************************************************
   // START wins anywhere so a repeated START reopens without STOP
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state_q  <= ST_IDLE;
         bitcnt_q <= 4'h0;
         shift_q  <= 8'h00;
         tx_q     <= 8'h00;
         ptr_q    <= PTR_RESET;
         rw_q     <= 1'b0;
         first_q  <= 1'b0;
         nack_q   <= 1'b0;
         oe_n_q   <= 1'b1;
      end else if (start_det) begin
         state_q  <= ST_ADDR;
         bitcnt_q <= 4'h0;
         oe_n_q   <= 1'b1;
      end else if (stop_det) begin
         state_q  <= ST_IDLE;
         oe_n_q   <= 1'b1;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               oe_n_q <= 1'b1;
            end
            ST_ADDR: begin
               if (scl_rise) begin
                  shift_q  <= {shift_q[6:0], sda_s_q};
                  bitcnt_q <= bitcnt_q + 4'h1;
               end else if (byte_done) begin
                  rw_q    <= shift_q[0];
                  oe_n_q  <= ~addr_hit;
                  state_q <= addr_hit ? ST_ADDR_ACK : ST_IDLE;
               end
            end
            ST_ADDR_ACK: begin
               if (scl_fall) begin
                  bitcnt_q <= 4'h0;
                  first_q  <= 1'b1;
                  if (rw_q) begin
                     tx_q    <= rd_data;
                     oe_n_q  <= rd_data[7];
                     ptr_q   <= ptr_q + 8'h01;
                     state_q <= ST_RD_BYTE;
                  end else begin
                     oe_n_q  <= 1'b1;
                     state_q <= ST_WR_BYTE;
                  end
               end
            end
            ST_WR_BYTE: begin
               if (scl_rise) begin
                  shift_q  <= {shift_q[6:0], sda_s_q};
                  bitcnt_q <= bitcnt_q + 4'h1;
               end else if (byte_done && first_q) begin
                  ptr_q   <= shift_q;
                  first_q <= 1'b0;
                  oe_n_q  <= 1'b0;
                  state_q <= ST_WR_ACK;
               end else if (byte_done) begin
                  // A full FIFO refuses the byte with a not-acknowledge
                  ptr_q   <= push ? ptr_q + 8'h01 : ptr_q;
                  oe_n_q  <= ~push_ready;
                  state_q <= push_ready ? ST_WR_ACK : ST_IDLE;
               end
            end
            ST_WR_ACK: begin
               if (scl_fall) begin
                  oe_n_q   <= 1'b1;
                  bitcnt_q <= 4'h0;
                  state_q  <= ST_WR_BYTE;
               end
            end
            ST_RD_BYTE: begin
               if (tx_last) begin
                  oe_n_q  <= 1'b1;
                  state_q <= ST_RD_ACK;
               end else if (scl_fall) begin
                  tx_q     <= {tx_q[6:0], 1'b0};
                  oe_n_q   <= tx_q[6];
                  bitcnt_q <= bitcnt_q + 4'h1;
               end
            end
            ST_RD_ACK: begin
               if (scl_rise) begin
                  nack_q <= sda_s_q;
               end else if (scl_fall && nack_q) begin
                  state_q <= ST_IDLE;
               end else if (ld_tx) begin
                  tx_q     <= rd_data;
                  oe_n_q   <= rd_data[7];
                  ptr_q    <= ptr_q + 8'h01;
                  bitcnt_q <= 4'h0;
                  state_q  <= ST_RD_BYTE;
               end
            end
         endcase
      end
   end

   // Open drain: the pin is only ever pulled low
   assign sda_out      = 1'b0;
   assign sda_oe_n_out = oe_n_q;

   // ****************************************************************
   // Write buffering and register file
   // ****************************************************************
   // Drain stalls on a transmit load so the read mux sees a stable file
   istar_fifo #(
      .WIDTH (FIFO_WIDTH),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .ref_clk_in    (ref_clk_in),
      .resetn_in     (resetn_in),
      .in_valid_in   (wr_data),
      .in_ready_out  (push_ready),
      .in_data_in    ({ptr_q, shift_q}),
      .out_valid_out (pop_valid),
      .out_ready_in  (~ld_tx),
      .out_data_out  (pop_data)
   );

   wire       pop_fire = pop_valid & ~ld_tx;
   wire [7:0] pop_idx  = pop_data.addr - SRAM_FIRST;
   // SRAM keeps no reset so its power-up content stays undefined
   always_ff @(posedge ref_clk_in) begin
      if (pop_fire && pop_data.addr >= SRAM_FIRST) begin
         sram_q[pop_idx] <= pop_data.data;
      end
   end
   // Trim register; temperature bytes take no bus write
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         trim_q <= TRIM_RESET;
      end else if (pop_fire && pop_data.addr == ADDR_TRIM) begin
         trim_q <= pop_data.data;
      end
   end
   // ****************************************************************
   // Conversion scheduling and trim application
   // ****************************************************************
   wire per_tick = (per_cnt_q == MANUAL_CONVERT_BIT_PERIOD - 40'h1);
   wire manual_convert_bit_req = per_tick | manual_convert_in | (start_det & bk_s_q);
   wire manual_convert_bit_go  = pend_q & ~busy_q;
   wire applies  = temp_result_in.valid & ((temp_result_in.code != temp_q) | man_q);
   // Request is held pending while busy, so none is lost
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         per_cnt_q <= 40'h0;
         pend_q    <= 1'b1;
         busy_q    <= 1'b0;
         man_q     <= 1'b0;
         start_q   <= 1'b0;
      end else begin
         per_cnt_q <= per_tick ? 40'h0 : per_cnt_q + 40'h1;
         pend_q    <= (pend_q & ~manual_convert_bit_go) | manual_convert_bit_req;
         start_q   <= manual_convert_bit_go;
         busy_q    <= manual_convert_bit_go | (busy_q & ~temp_result_in.valid);
         man_q     <= (man_q & ~temp_result_in.valid) | (manual_convert_in & ~busy_q);
      end
   end
   // Result updates when a conversion ends; capacitance setting only if the code changed or the conversion was manual
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         temp_q <= TEMP_RESET;
         cap_q  <= CAP_RESET;
      end else begin
         if (temp_result_in.valid) begin
            temp_q <= temp_result_in.code;
         end
         if (applies) begin
            cap_q <= cap_apply(cap_base_in, trim_q);
         end
      end
   end
   assign manual_convert_bit_start_out = start_q;
   assign manual_convert_bit_busy_out  = busy_q;
   assign cap_trim_out   = cap_q;
   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!resetn_in);
   addr_ack_a: assert property ((state_q == ST_ADDR) && byte_done && addr_hit
      |=> !sda_oe_n_out && state_q == ST_ADDR_ACK)
      else $error("address not acknowledged");
   ack_hold_a: assert property ((state_q == ST_ADDR_ACK || state_q == ST_WR_ACK)
      |-> !sda_oe_n_out)
      else $error("acknowledge released early");
   addr_miss_a: assert property ((state_q == ST_ADDR) && byte_done && !addr_hit
      |=> sda_oe_n_out && state_q == ST_IDLE)
      else $error("foreign address acknowledged");
   temp_ro_a: assert property (pop_fire && (pop_data.addr == ADDR_TEMP_INT
      || pop_data.addr == ADDR_TEMP_FRAC) && !temp_result_in.valid |=> $stable(temp_q))
      else $error("temperature changed by bus write");
   frac_zero_a: assert property (ptr_q == ADDR_TEMP_FRAC |-> rd_data[5:0] == 6'h00
      && rd_data[7:TEMP_FRAC_POS] == temp_q[1:0])
      else $error("fraction byte layout wrong");
   stop_idle_a: assert property (stop_det |=> state_q == ST_IDLE && sda_oe_n_out)
      else $error("stop did not release the bus");
   nack_rel_a: assert property (state_q == ST_RD_ACK |-> sda_oe_n_out)
      else $error("data held during master acknowledge");
   msb_first_a: assert property (state_q == ST_RD_BYTE |-> sda_oe_n_out == tx_q[7])
      else $error("transmit bit order wrong");
   stable_hi_a: assert property (state_q == ST_RD_BYTE && $changed(sda_oe_n_out)
      |-> !scl_s_q)
      else $error("data changed while clock high");
   ptr_step_a: assert property (push |=> ptr_q == $past(ptr_q) + 8'h01)
      else $error("pointer did not advance");
   trim_add_a: assert property (temp_result_in.valid && man_q
      |=> cap_trim_out == cap_apply($past(cap_base_in), $past(trim_q)))
      else $error("trim not applied on manual conversion");
   manual_convert_bit_go_a: assert property (pend_q && !busy_q |=> manual_convert_bit_start_out ##1 !manual_convert_bit_start_out)
      else $error("conversion not started");
   wr_xfer_c: cover property (push ##[1:400] (state_q == ST_WR_ACK));
   rd_xfer_c: cover property ((state_q == ST_RD_ACK) && scl_rise && !sda_s_q);
   rd_nack_c: cover property ((state_q == ST_RD_ACK) && scl_fall && nack_q);
   fifo_full_c: cover property (wr_data && !push_ready);
endmodule

// ---- bench/istar_bus_master.sv ----
// Bus master model: drives the link clock and pulls the data line low as an open-drain party
`timescale 1ns/10ps
module istar_bus_master #(
   parameter real HALF = 24.0
) (
   output logic      scl_out,
   output logic      sda_low_out,
   input  wire logic sda_in
);
   // Clock stands high and data is released outside frames
   initial begin
      scl_out = 1'b1;
      sda_low_out = 1'b0;
   end
   // One bit: data moves mid-low, sampled late in the high phase so slow answers still count
   task automatic bit_x(input logic v, output logic s);
      sda_low_out = ~v;
      #(HALF / 2);
      scl_out = 1'b1;
      #(HALF);
      s = sda_in;
      scl_out = 1'b0;
      #(HALF / 2);
   endtask
   // START and repeated START: both lines high before data falls
   task automatic start();
      sda_low_out = 1'b0;
      #(HALF / 2);
      scl_out = 1'b1;
      #(HALF);
      sda_low_out = 1'b1;
      #(HALF);
      scl_out = 1'b0;
      #(HALF / 2);
   endtask
   task automatic stop();
      sda_low_out = 1'b1;
      #(HALF / 2);
      scl_out = 1'b1;
      #(HALF);
      sda_low_out = 1'b0;
      #(HALF);
   endtask
   // Byte out, top bit first; the ninth slot returns the acknowledge
   task automatic wbyte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_x(b[i], s);
      bit_x(1'b1, s);
      ack = ~s;
   endtask
   // Byte in; the last one is left unacknowledged
   task automatic rbyte(output logic [7:0] b, input logic last);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_x(1'b1, s);
         b[i] = s;
      end
      bit_x(last, s);
   endtask
endmodule

// ---- bench/istar_slave_tb_top.sv ----
// Testbench: register transfers, conversions and trim results of the serial slave
`timescale 1ns/10ps
module istar_slave_tb_top;
   import istar_pkg::*;
   logic        ref_clk_in = 1'b0;
   logic        resetn_in = 1'b0;
   logic        manual_convert_in = 1'b0;
   logic        on_backup = 1'b0;
   istar_temp_t temp_result_in = '0;
   logic [7:0]  cap_base_in = 8'h00;
   logic        scl, m_low, sda_w, sda_o, oe_n, manual_convert_bit_start, busy, a0;
   logic [7:0]  cap_trim, p, tv[4];
   logic [9:0]  c1;
   logic [15:0] d, e, got;
   int          fail_count = 0;
   int          compares = 0;
   int          cycles = 0;
   int          starts = 0;
   // Pulled-up wire: low while either party pulls
   assign sda_w = ~(m_low | ~oe_n);
   always #2.5 ref_clk_in = ~ref_clk_in;
   istar_bus_master m (.scl_out(scl), .sda_low_out(m_low), .sda_in(sda_w));
   // Long period keeps periodic requests out of the manual trim checks
   istar_slave #(.MANUAL_CONVERT_BIT_PERIOD(40'h13880)) dut (
      .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .scl_in(scl), .sda_in(sda_w),
      .sda_out(sda_o), .sda_oe_n_out(oe_n), .on_backup_in(on_backup),
      .manual_convert_in(manual_convert_in), .manual_convert_bit_start_out(manual_convert_bit_start),
      .manual_convert_bit_busy_out(busy), .temp_result_in(temp_result_in),
      .cap_base_in(cap_base_in), .cap_trim_out(cap_trim));
   function automatic logic [7:0] clamp(input logic [7:0] b, input logic [7:0] t);
      int s;
      s = int'(b) + int'($signed(t));
      return (s < 0) ? 8'h00 : ((s > 255) ? 8'hff : s[7:0]);
   endfunction
   task automatic check(input string n, input logic [15:0] x, input logic [15:0] g);
      compares++;
      if (g !== x) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", n, x, g);
      end
   endtask
   task automatic final_report();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic wr(input logic [7:0] ptr, input logic [15:0] dv, input int n);
      logic a;
      m.start();
      m.wbyte({DEV_ADDR, 1'b0}, a);
      check("write addr ack", 16'h0001, 16'(a));
      m.wbyte(ptr, a);
      for (int i = 0; i < n; i++) m.wbyte(dv[15 - 8 * i -: 8], a);
      check("write data ack", 16'h0001, 16'(a));
      m.stop();
   endtask
   // Optional pointer write, then a repeated START and a two-byte read
   task automatic rd(input logic setp, input logic [7:0] ptr, output logic [15:0] dv);
      logic a;
      if (setp) begin
         m.start();
         m.wbyte({DEV_ADDR, 1'b0}, a);
         m.wbyte(ptr, a);
      end
      m.start();
      m.wbyte({DEV_ADDR, 1'b1}, a);
      check("read addr ack", 16'h0001, 16'(a));
      m.rbyte(dv[15:8], 1'b0);
      m.rbyte(dv[7:0], 1'b1);
      m.stop();
   endtask
   // Sensor stand-in: wait for busy under a bound, then hand back one result
   task automatic manual_convert_bit(input logic [9:0] c, input logic [7:0] b);
      @(negedge ref_clk_in);
      for (int k = 0; k < 50 && busy !== 1'b1; k++) @(negedge ref_clk_in);
      check("busy", 16'h0001, 16'(busy));
      temp_result_in = '{1'b1, c};
      cap_base_in = b;
      @(negedge ref_clk_in);
      temp_result_in.valid = 1'b0;
      repeat (3) @(negedge ref_clk_in);
   endtask
   // Counted on the falling edge, away from the launching edge, so the one-cycle start pulse is settled
   always @(negedge ref_clk_in) begin
      cycles++;
      if (manual_convert_bit_start === 1'b1) starts++;
      if (cycles == 60000) begin
         fail_count++;
         final_report();
      end
   end
   initial begin
      d = 16'($urandom(96025));
      tv = '{8'h7f, 8'h80, 8'h01, 8'hff};
      repeat (10) @(negedge ref_clk_in);
      resetn_in = 1'b1;
      c1 = 10'($urandom_range(1023, 1));
      rd(1'b1, ADDR_TEMP_INT, got);
      check("temp at reset", 16'h0000, got);
      manual_convert_bit(c1, 8'h80);
      check("cap no trim", {8'h00, clamp(8'h80, 8'h00)}, {8'h00, cap_trim});
      rd(1'b1, ADDR_TEMP_INT, got);
      check("temp regs", {c1[9:2], c1[1:0], 6'h00}, got);
      wr(ADDR_TEMP_INT, ~got, 2);
      rd(1'b1, ADDR_TEMP_INT, got);
      check("temp read only", {c1[9:2], c1[1:0], 6'h00}, got);
      // Random storage spans, then a read that carries on from the pointer
      repeat (4) begin
         p = 8'($urandom_range(252, 20));
         d = 16'($urandom);
         e = 16'($urandom);
         wr(p, d, 2);
         wr(p + 8'h02, e, 2);
         rd(1'b1, p, got);
         check("sram pair", d, got);
         rd(1'b0, p, got);
         check("pointer kept", e, got);
      end
      wr(8'hff, d, 2);
      rd(1'b1, 8'hff, got);
      check("pointer wrap", {d[15:8], 8'h00}, got);
      // Trim extremes and unit steps against random bases, each applied by a manual conversion
      foreach (tv[i]) begin
         wr(ADDR_TRIM, {tv[i], 8'h00}, 1);
         @(negedge ref_clk_in);
         manual_convert_in = 1'b1;
         @(negedge ref_clk_in);
         manual_convert_in = 1'b0;
         p = 8'($urandom);
         manual_convert_bit(c1, p);
         check("cap trim", {8'h00, clamp(p, tv[i])}, {8'h00, cap_trim});
      end
      // Foreign address while on backup: the START alone asks for a conversion
      @(negedge ref_clk_in);
      on_backup = 1'b1;
      m.start();
      m.wbyte({DEV_ADDR ^ 7'h01, 1'b0}, a0);
      m.stop();
      check("foreign addr ack", 16'h0000, 16'(a0));
      manual_convert_bit(c1, 8'h40);
      check("cap kept", {8'h00, clamp(p, tv[3])}, {8'h00, cap_trim});
      check("manual_convert_bit starts", 16'h0006, 16'(starts));
      check("sda pull level", 16'h0000, 16'(sda_o));
      final_report();
   end
endmodule
